// ---- logic/fsps_pkg.sv ----
/*
  fsps_pkg: shared constants for the flash self-programming sequencer.
  Assumes a 20 MHz ref_clk and a byte-wide register port with 3-bit address.
*/
`default_nettype none

package fsps_pkg;

  // ***************************************************
  // register map
  // ***************************************************
  localparam logic [2:0] ADR_CTRL    = 3'h0;
  localparam logic [2:0] ADR_PTR_LO  = 3'h1;
  localparam logic [2:0] ADR_PTR_HI  = 3'h2;
  localparam logic [2:0] ADR_DATA_LO = 3'h3;
  localparam logic [2:0] ADR_DATA_HI = 3'h4;
  localparam logic [2:0] ADR_STORE   = 3'h5;
  localparam logic [2:0] ADR_LOAD    = 3'h6;

  // ***************************************************
  // control register fields and command codes
  // ***************************************************
  localparam int B_EN   = 0;
  localparam int B_REEN = 4;
  localparam int B_BUSY = 6;
  localparam int B_IE   = 7;
  localparam logic [6:0] CMD_LOAD  = 7'h01;
  localparam logic [6:0] CMD_ERASE = 7'h03;
  localparam logic [6:0] CMD_WRITE = 7'h05;
  localparam logic [6:0] CMD_LOCK  = 7'h09;
  localparam logic [6:0] CMD_REEN  = 7'h11;

  // ***************************************************
  // values after reset and timing
  // ***************************************************
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
  localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
  localparam logic [2:0]  ARM_CYCLES     = 3'h4;
  localparam logic [2:0]  VEC_WAIT       = 3'h4;
  localparam int CLK_PERIOD_NS    = 50;
  localparam int PROG_MIN_NS      = 3700000;
  localparam int PROG_CYCLES_DFLT = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ARMED  = 4'h2,
    ST_STREAM = 4'h4,
    ST_BUSY   = 4'h8
  } fsps_state_t;

  typedef enum logic [1:0] {
    OP_NONE  = 2'h0,
    OP_ERASE = 2'h1,
    OP_WRITE = 2'h2,
    OP_LOCK  = 2'h3
  } fsps_op_t;

endpackage

`default_nettype wire

// ---- logic/fsps_sync3.sv ----
/*
  fsps_sync3: three-stage input synchroniser for a pin level.
  Assumes the input is asynchronous to ref_clk; output moves when stages two and three agree.
*/
`timescale 1ns/1ns
`default_nettype none

module fsps_sync3 import fsps_pkg::*; #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic d,
  output var  logic q
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } fsps_sync_st_t;

  fsps_sync_st_t s;
  fsps_sync_st_t next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // a single-stage glitch never reaches q
    if (s.s2 == s.s3) begin
      next_s.q = s.s3;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= {4{RESET_VAL}};
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;

endmodule // fsps_sync3

`default_nettype wire

// ---- logic/fsps_op_timer.sv ----
/*
  fsps_op_timer: one-shot programming-time counter.
  Assumes start is a one-cycle pulse from the sequencer; done pulses once when the count expires.
*/
`timescale 1ns/1ns
`default_nettype none

module fsps_op_timer import fsps_pkg::*; #(
  parameter int TIMER_W = 17
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               start,
  input  wire logic [TIMER_W-1:0] load,
  output var  logic               done
);

  typedef struct packed {
    logic [TIMER_W-1:0] cnt;
    logic               run;
    logic               done;
  } fsps_tmr_st_t;

  fsps_tmr_st_t s;
  fsps_tmr_st_t next_s;

  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (start) begin
      next_s.cnt = load;
      next_s.run = 1'b1;
    end else if (s.run) begin
      if (s.cnt <= TIMER_W'(1)) begin
        next_s.run  = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - TIMER_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;

endmodule // fsps_op_timer

`default_nettype wire

// ---- logic/fsps_core.sv ----
/*
  fsps_core: flash self-programming sequencer top.
  Assumes the core drives the register port on ref_clk, eeprom_write comes from same-clock
  logic, and the flash array takes streamed words and go pulses from this block.
*/
// Functional notes
// [RULE1] reset vector is 0x0000 with fuse at one, boot address when zero
// [RULE2] the fuse is an input only; nothing here can change it
// [RULE3] store commands take their address from the 16-bit pointer bytes
// [RULE4] pointer low bits pick word in page, high bits pick page
// [RULE5] target page is latched at start; pointer changes later do nothing
// [RULE6] lock-set command ignores the pointer completely
// [RULE7] program-memory loads use pointer bit zero to pick the byte
// [RULE8] software erases a page before writing; buffer fill before or after
// [RULE9] buffer word loads are accepted in any order
// [RULE10] erase code executes within four cycles, page field only used
// [RULE11] erase to halting section stalls core; concurrent section stays readable
// [RULE12] load code executes within four cycles, data pair into word slot
// [RULE13] buffer clears after page write, on re-enable write, and on reset
// [RULE14] software loads each buffer word once between clears
// [RULE15] an EEPROM write during buffer loading discards the loaded data
// [RULE16] write code executes within four cycles, buffer into latched page
// [RULE17] write to halting section stalls core for the whole operation
// [RULE18] software points erase and write at the same page
// [RULE19] enabled interrupt stays asserted while the enable bit reads clear
// [RULE20] software should lock the boot section when it needs no change
// [RULE21] busy flag stays set while concurrent section blocked, re-enable clears
// [RULE22] command bits auto-clear when no store strobe follows in four cycles
// [RULE23] enable bit clears when erase, load or write completes
`timescale 1ns/1ns
`default_nettype none

module fsps_core import fsps_pkg::*; #(
  parameter int          PAGE_WORDS      = 64,
  parameter int          HALTING_SECTION_FIRST_PAGE = 448,
  parameter logic [15:0] BOOT_RESET_ADDR = 16'h3800,
  parameter int          PROG_CYCLES     = PROG_CYCLES_DFLT,
  parameter int          TIMER_W         = 17
) (
  input  wire logic                               ref_clk,
  input  wire logic                               rst_n,
  input  wire logic [2:0]                         reg_addr,
  input  wire logic [7:0]                         reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output var  logic [7:0]                         reg_rdata,
  input  wire logic                               boot_reset_select_fuse,
  input  wire logic                               eeprom_write,
  input  wire logic [15:0]                        flash_rd_word,
  output var  logic [14:0]                        flash_rd_addr,
  output var  logic [15:0]                        reset_vector,
  output var  logic                               cpu_halt,
  output var  logic                               spm_irq,
  output var  logic                               flash_erase_go,
  output var  logic                               flash_write_go,
  output var  logic                               flash_lock_go,
  output var  logic [7:0]                         flash_lock_data,
  output var  logic [15-$clog2(PAGE_WORDS)-1:0]   flash_page,
  output var  logic                               flash_word_we,
  output var  logic [$clog2(PAGE_WORDS)-1:0]      flash_word_idx,
  output var  logic [15:0]                        flash_word_data
);

  localparam int W  = $clog2(PAGE_WORDS);
  localparam int PB = 15 - W;

  // ***************************************************
  // parameter checks
  // ***************************************************
  generate
    if (PAGE_WORDS < 2 || (PAGE_WORDS & (PAGE_WORDS - 1)) != 0 || W > 14) begin : g_bad_page
      $error("PAGE_WORDS must be a power of two from 2 to 16384");
    end
    if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << TIMER_W)) begin : g_bad_time
      $error("PROG_CYCLES does not fit the timer");
    end
  endgenerate

  typedef struct packed {
    fsps_state_t              state;
    fsps_op_t                 op;
    logic [7:0]               ctrl;
    logic [15:0]              ptr;
    logic [15:0]              data;
    logic [2:0]               arm_cnt;
    logic [PB-1:0]            page;
    logic                     halt_tgt;
    logic [W-1:0]             idx;
    logic [PAGE_WORDS-1:0][15:0] buf_word;
    logic                     buf_dirty;
    logic [2:0]               vec_wait;
    logic                     vec_done;
    logic [15:0]              vector;
    logic [7:0]               rdata;
    logic                     erase_go;
    logic                     write_go;
    logic                     lock_go;
    logic [7:0]               lock_data;
    logic                     word_we;
    logic [W-1:0]             word_idx;
    logic [15:0]              word_data;
    logic                     cpu_halt;
    logic                     irq;
    logic [14:0]              rd_addr;
    logic                     tmr_start;
  } fsps_core_st_t;

  fsps_core_st_t s;
  fsps_core_st_t next_s;
  logic          fuse_q;
  logic          tmr_done;
  logic          store_hit;
  logic [W-1:0]  ptr_word;
  logic [PB-1:0] ptr_page;

  function automatic logic is_cmd(input logic [4:0] bits, input logic [6:0] code);
    is_cmd = ({2'b00, bits} == code);
  endfunction

  // ***************************************************
  // helpers
  // ***************************************************
  // [RULE2] fuse only observed
  fsps_sync3 #(
    .RESET_VAL (1'b1)
  ) u_fuse_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       (boot_reset_select_fuse),
    .q       (fuse_q)
  );

  fsps_op_timer #(
    .TIMER_W (TIMER_W)
  ) u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (s.tmr_start),
    .load    (TIMER_W'(PROG_CYCLES)),
    .done    (tmr_done)
  );

  // [RULE4] word and page fields
  assign ptr_word  = s.ptr[W:1];
  assign ptr_page  = s.ptr[15:W+1];
  assign store_hit = reg_wr && reg_addr == ADR_STORE && s.state == ST_ARMED;

  // ***************************************************
  // sequencer
  // ***************************************************
  always_comb begin
    next_s           = s;
    next_s.rdata     = 8'h00;
    next_s.erase_go  = 1'b0;
    next_s.write_go  = 1'b0;
    next_s.lock_go   = 1'b0;
    next_s.word_we   = 1'b0;
    next_s.tmr_start = 1'b0;

    // [RULE1] vector picked once the fuse level has settled
    if (!s.vec_done) begin
      next_s.vec_wait = s.vec_wait + 3'h1;
      if (s.vec_wait == VEC_WAIT) begin
        next_s.vec_done = 1'b1;
        next_s.vector   = fuse_q ? APP_RESET_ADDR : BOOT_RESET_ADDR;
      end
    end

    // [RULE3] pointer and data pair
    if (reg_wr) begin
      case (reg_addr)
        ADR_PTR_LO:  next_s.ptr[7:0]   = reg_wdata;
        ADR_PTR_HI:  next_s.ptr[15:8]  = reg_wdata;
        ADR_DATA_LO: next_s.data[7:0]  = reg_wdata;
        ADR_DATA_HI: next_s.data[15:8] = reg_wdata;
        ADR_CTRL: begin
          next_s.ctrl[B_IE] = reg_wdata[B_IE];
          if (s.state == ST_IDLE && reg_wdata[B_EN]) begin
            if (is_cmd(reg_wdata[4:0], CMD_REEN)) begin
              // [RULE13] re-enable clears the buffer
              next_s.buf_word  = {PAGE_WORDS{ERASED_WORD}};
              next_s.buf_dirty = 1'b0;
              // [RULE21] busy flag cleared by re-enable
              next_s.ctrl[B_BUSY] = 1'b0;
            end else if (is_cmd(reg_wdata[4:0], CMD_LOAD) || is_cmd(reg_wdata[4:0], CMD_ERASE) ||
                         is_cmd(reg_wdata[4:0], CMD_WRITE) || is_cmd(reg_wdata[4:0], CMD_LOCK)) begin
              next_s.ctrl[4:0] = reg_wdata[4:0];
              next_s.state     = ST_ARMED;
              next_s.arm_cnt   = 3'h0;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // [RULE15] eeprom write drops a partly loaded buffer
    // placed before the store so that a load in the same cycle still lands
    if (eeprom_write && s.buf_dirty && s.state != ST_STREAM && s.state != ST_BUSY) begin
      next_s.buf_word  = {PAGE_WORDS{ERASED_WORD}};
      next_s.buf_dirty = 1'b0;
    end

    case (s.state)
      ST_IDLE: begin
      end
      ST_ARMED: begin
        if (store_hit) begin
          if (is_cmd(s.ctrl[4:0], CMD_LOAD)) begin
            // [RULE12] data pair into the addressed slot
            // [RULE9] any slot, any order
            next_s.buf_word[ptr_word] = s.data;
            next_s.buf_dirty          = 1'b1;
            // [RULE23] load done at once
            next_s.ctrl[4:0] = 5'h00;
            next_s.state     = ST_IDLE;
          end else if (is_cmd(s.ctrl[4:0], CMD_LOCK)) begin
            // [RULE6] pointer not used
            next_s.lock_go   = 1'b1;
            next_s.lock_data = s.data[7:0];
            next_s.op        = OP_LOCK;
            next_s.tmr_start = 1'b1;
            next_s.state     = ST_BUSY;
          end else begin
            // [RULE5] page latched here
            next_s.page     = ptr_page;
            next_s.halt_tgt = (ptr_page >= PB'(HALTING_SECTION_FIRST_PAGE));
            // [RULE11] stall or block
            // [RULE17] same split for writes
            if (ptr_page >= PB'(HALTING_SECTION_FIRST_PAGE)) begin
              next_s.cpu_halt = 1'b1;
            end else begin
              next_s.ctrl[B_BUSY] = 1'b1;
            end
            if (is_cmd(s.ctrl[4:0], CMD_ERASE)) begin
              // [RULE10] erase only uses the page field
              next_s.erase_go  = 1'b1;
              next_s.op        = OP_ERASE;
              next_s.tmr_start = 1'b1;
              next_s.state     = ST_BUSY;
            end else begin
              // [RULE16] buffer streamed to the latched page
              next_s.write_go = 1'b1;
              next_s.op       = OP_WRITE;
              next_s.idx      = '0;
              next_s.state    = ST_STREAM;
            end
          end
        end else begin
          // [RULE22] window of four cycles
          next_s.arm_cnt = s.arm_cnt + 3'h1;
          if (s.arm_cnt == ARM_CYCLES - 3'h1) begin
            next_s.ctrl[4:0] = 5'h00;
            next_s.state     = ST_IDLE;
          end
        end
      end
      ST_STREAM: begin
        next_s.word_we   = 1'b1;
        next_s.word_idx  = s.idx;
        next_s.word_data = s.buf_word[s.idx];
        next_s.idx       = s.idx + W'(1);
        if (s.idx == W'(PAGE_WORDS - 1)) begin
          next_s.tmr_start = 1'b1;
          next_s.state     = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (tmr_done) begin
          // [RULE23] completion clears the enable bit
          next_s.ctrl[4:0] = 5'h00;
          next_s.cpu_halt  = 1'b0;
          next_s.state     = ST_IDLE;
          if (s.op == OP_WRITE) begin
            // [RULE13] cleared after page write
            next_s.buf_word  = {PAGE_WORDS{ERASED_WORD}};
            next_s.buf_dirty = 1'b0;
          end
          next_s.op = OP_NONE;
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase

    // [RULE7] byte pick by pointer bit zero
    if (reg_rd) begin
      case (reg_addr)
        ADR_CTRL:    next_s.rdata = {s.ctrl[7:6], 1'b0, s.ctrl[4:0]};
        ADR_PTR_LO:  next_s.rdata = s.ptr[7:0];
        ADR_PTR_HI:  next_s.rdata = s.ptr[15:8];
        ADR_DATA_LO: next_s.rdata = s.data[7:0];
        ADR_DATA_HI: next_s.rdata = s.data[15:8];
        ADR_LOAD:    next_s.rdata = s.ptr[0] ? flash_rd_word[15:8] : flash_rd_word[7:0];
        default:     next_s.rdata = 8'h00;
      endcase
    end

    // [RULE19] level interrupt while enable reads clear
    next_s.irq     = next_s.ctrl[B_IE] & ~next_s.ctrl[B_EN];
    next_s.rd_addr = next_s.ptr[15:1];
  end

  // [RULE13] reset empties the buffer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s          <= '0;
      s.state    <= ST_IDLE;
      s.buf_word <= {PAGE_WORDS{ERASED_WORD}};
    end else begin
      s <= next_s;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign reg_rdata       = s.rdata;
  assign flash_rd_addr   = s.rd_addr;
  assign reset_vector    = s.vector;
  assign cpu_halt        = s.cpu_halt;
  assign spm_irq         = s.irq;
  assign flash_erase_go  = s.erase_go;
  assign flash_write_go  = s.write_go;
  assign flash_lock_go   = s.lock_go;
  assign flash_lock_data = s.lock_data;
  assign flash_page      = s.page;
  assign flash_word_we   = s.word_we;
  assign flash_word_idx  = s.word_idx;
  assign flash_word_data = s.word_data;

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_vector_pick: assert property ($rose(s.vec_done) |-> s.vector == ($past(fuse_q) ? APP_RESET_ADDR : BOOT_RESET_ADDR)) else $error("reset vector wrong"); // [RULE1]
  a_arm_timeout: assert property (s.state == ST_ARMED && s.arm_cnt == 3'h3 && !store_hit |=> s.state == ST_IDLE && !s.ctrl[B_EN]) else $error("command bits not cleared"); // [RULE22]
  a_erase_page: assert property (store_hit && s.ctrl[4:0] == 5'h03 |=> s.erase_go && s.page == $past(ptr_page) && s.state == ST_BUSY) else $error("erase start wrong"); // [RULE10]
  a_load_slot: assert property (store_hit && s.ctrl[4:0] == 5'h01 |=> s.buf_word[$past(ptr_word)] == $past(s.data) && !s.ctrl[B_EN]) else $error("load slot wrong"); // [RULE12]
  a_page_held: assert property (s.state == ST_BUSY ##1 s.state == ST_BUSY |-> $stable(s.page)) else $error("latched page moved"); // [RULE5]
  a_write_clear: assert property (s.state == ST_BUSY && s.op == OP_WRITE && tmr_done |=> !s.buf_dirty && s.buf_word[0] == ERASED_WORD) else $error("buffer kept after write"); // [RULE13]
  a_eeprom_drop: assert property (eeprom_write && s.buf_dirty && s.state inside {ST_IDLE, ST_ARMED} && !store_hit |=> !s.buf_dirty) else $error("eeprom did not drop buffer"); // [RULE15]
  a_irq_level: assert property ($fell(s.ctrl[B_EN]) && s.ctrl[B_IE] |-> ##1 s.irq [*2]) else $error("interrupt not asserted"); // [RULE19]
  a_halt_split: assert property (store_hit && s.ctrl[2:1] != 2'b00 |=> (s.cpu_halt != s.ctrl[B_BUSY]) || $past(s.ctrl[B_BUSY])) else $error("halt and busy both or neither"); // [RULE11]
  a_stream_halt: assert property (s.state == ST_STREAM && s.halt_tgt |-> s.cpu_halt) else $error("no stall during halting write"); // [RULE17]
  a_done_enable: assert property (s.state == ST_BUSY && tmr_done |=> !s.ctrl[B_EN] && !s.cpu_halt) else $error("enable not cleared at completion"); // [RULE23]
  a_busy_hold: assert property (s.ctrl[B_BUSY] && !(reg_wr && reg_addr == ADR_CTRL) |=> s.ctrl[B_BUSY]) else $error("busy flag dropped alone"); // [RULE21]

  c_load: cover property (store_hit && s.ctrl[4:0] == 5'h01);
  c_erase_done: cover property (s.op == OP_ERASE && tmr_done);
  c_write_done: cover property (s.op == OP_WRITE && tmr_done);
  c_timeout: cover property (s.state == ST_ARMED ##1 s.state == ST_IDLE && s.op == OP_NONE);

endmodule // fsps_core

`default_nettype wire

// ---- bench/fsps_flash_model.sv ----
/*
  fsps_flash_model: behavioural flash array at the far side of the sequencer.
  Assumes go pulses and word strobes are registered on ref_clk, one word a cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module fsps_flash_model (
  input  wire logic        ref_clk,
  input  wire logic [14:0] rd_addr,
  output var  logic [15:0] rd_word,
  input  wire logic        erase_go,
  input  wire logic [8:0]  page,
  input  wire logic        word_we,
  input  wire logic [5:0]  word_idx,
  input  wire logic [15:0] word_data
);
  // ***********************
  // array
  // ***********************
  logic [15:0] mem [0:32767];
  initial for (int i = 0; i < 32768; i++) mem[i] = 16'hFFFF;
  // reads are combinational, so a freshly written word shows up at once
  assign rd_word = mem[rd_addr];
  always @(posedge ref_clk) begin
    if (erase_go) for (int i = 0; i < 64; i++) mem[{page, i[5:0]}] <= 16'hFFFF;
    if (word_we) mem[{page, word_idx}] <= word_data;
  end
endmodule // fsps_flash_model

`default_nettype wire

// ---- bench/testbench.sv ----
/*
  testbench: self-checking bench for fsps_core with a flash model.
  Assumes PROG_CYCLES shortened to 20 and 64-word pages.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench import fsps_pkg::*;;
  // ***********************
  // signals
  // ***********************
  localparam logic [15:0] BOOT = 16'h3800;
  logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, fuse = 0, eeprom_write = 0;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, lock_data;
  logic [14:0] rd_addr;
  logic [15:0] rd_word, reset_vector, word_data;
  logic        cpu_halt, spm_irq, erase_go, write_go, lock_go, word_we;
  logic [8:0]  page;
  logic [5:0]  word_idx;
  int errors = 0, compares = 0;
  always #25 ref_clk = ~ref_clk;

  fsps_core #(.PROG_CYCLES(20), .BOOT_RESET_ADDR(BOOT)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .boot_reset_select_fuse(fuse), .eeprom_write(eeprom_write), .flash_rd_word(rd_word),
    .flash_rd_addr(rd_addr), .reset_vector(reset_vector), .cpu_halt(cpu_halt), .spm_irq(spm_irq),
    .flash_erase_go(erase_go), .flash_write_go(write_go), .flash_lock_go(lock_go),
    .flash_lock_data(lock_data), .flash_page(page), .flash_word_we(word_we),
    .flash_word_idx(word_idx), .flash_word_data(word_data));
  fsps_flash_model flash (.ref_clk(ref_clk), .rd_addr(rd_addr), .rd_word(rd_word), .erase_go(erase_go),
    .page(page), .word_we(word_we), .word_idx(word_idx), .word_data(word_data));

  // ***********************
  // shared tasks
  // ***********************
  task summarize;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] q);
    @(posedge ref_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task setp(input logic [15:0] p);
    wr(ADR_PTR_LO, p[7:0]);
    wr(ADR_PTR_HI, p[15:8]);
  endtask
  function automatic logic [15:0] za(input int pg, input int w);
    return {pg[8:0], w[5:0], 1'b0};
  endfunction
  task lpm(input logic [15:0] p, input logic [7:0] e);
    logic [7:0] q;
    setp(p);
    rd(ADR_LOAD, q);
    chk({8'h00, q}, {8'h00, e});
  endtask
  task waitirq(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #1;
      if (spm_irq === 1'b1) break;
    end
    if (i == n) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      summarize;
    end
  endtask
  task ld(input logic [15:0] p, input logic [15:0] d);
    logic [7:0] q;
    setp(p);
    wr(ADR_DATA_LO, d[7:0]);
    wr(ADR_DATA_HI, d[15:8]);
    wr(ADR_CTRL, {1'b0, CMD_LOAD});
    wr(ADR_STORE, 8'h00);
    rd(ADR_CTRL, q);
    chk(16'(q[B_EN]), 16'h0000);
    chk(16'(spm_irq), 16'h0000);
  endtask
  // pointer is overwritten right after the store, so the page must come from the latch
  task op(input logic [6:0] cmd, input int pg, input logic halt);
    logic [7:0] q;
    setp(za(pg, 0));
    wr(ADR_CTRL, {1'b1, cmd});
    wr(ADR_STORE, 8'h00);
    #1 chk(16'({erase_go, write_go}), 16'({cmd == CMD_ERASE, cmd == CMD_WRITE}));
    wr(ADR_PTR_HI, 8'hFF);
    #1 chk(16'(cpu_halt), 16'(halt));
    waitirq(200);
    chk(16'(page), 16'(pg));
    chk(16'(cpu_halt), 16'h0000);
    rd(ADR_CTRL, q);
    chk(16'(q[B_EN]), 16'h0000);
    chk(16'(spm_irq), 16'h0001);
  endtask

  // ***********************
  // scenarios
  // ***********************
  task t_reset(input logic f, input logic [15:0] v);
    @(posedge ref_clk);
    rst_n <= 1'b0; fuse <= f;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 chk(reset_vector, v);
    $display("test reset done errors=%0d", errors);
  endtask
  task t_timeout;
    logic [7:0] q;
    wr(ADR_CTRL, {1'b0, CMD_ERASE});
    repeat (5) @(posedge ref_clk);
    rd(ADR_CTRL, q);
    chk(16'(q[3:0]), 16'h0000);
    $display("test timeout done errors=%0d", errors);
  endtask
  task t_page;
    logic [7:0] q;
    ld(za(1, 5), 16'hA55A);
    ld(za(1, 0), 16'h1234);
    op(CMD_ERASE, 1, 1'b0);
    rd(ADR_CTRL, q);
    chk(16'(q[B_BUSY]), 16'h0001);
    op(CMD_WRITE, 1, 1'b0);
    lpm(za(1, 5) | 16'h0001, 8'hA5);
    lpm(za(1, 0), 8'h34);
    wr(ADR_CTRL, {1'b0, CMD_REEN});
    rd(ADR_CTRL, q);
    chk(16'(q[B_BUSY]), 16'h0000);
    $display("test page done errors=%0d", errors);
  endtask
  // the second erase must wipe what the write put there
  task t_halt;
    ld(za(448, 7), 16'h5AA5);
    op(CMD_ERASE, 448, 1'b1);
    op(CMD_WRITE, 448, 1'b1);
    lpm(za(448, 7) | 16'h0001, 8'h5A);
    op(CMD_ERASE, 448, 1'b1);
    lpm(za(448, 7) | 16'h0001, 8'hFF);
    $display("test halt done errors=%0d", errors);
  endtask
  // each loaded word must vanish before the write, whichever way it was dropped
  task t_clear;
    ld(za(2, 3), 16'h0F0F);
    wr(ADR_CTRL, {1'b0, CMD_REEN});
    op(CMD_WRITE, 2, 1'b0);
    lpm(za(2, 3), 8'hFF);
    ld(za(3, 3), 16'h0F0F);
    @(posedge ref_clk);
    eeprom_write <= 1'b1;
    @(posedge ref_clk);
    eeprom_write <= 1'b0;
    op(CMD_WRITE, 3, 1'b0);
    lpm(za(3, 3), 8'hFF);
    $display("test clear done errors=%0d", errors);
  endtask
  // the pointer aims at a halting page, which a lock-set must neither latch nor stall on
  task t_lock;
    setp(za(448, 0));
    wr(ADR_DATA_LO, 8'hC3);
    wr(ADR_CTRL, {1'b1, CMD_LOCK});
    wr(ADR_STORE, 8'h00);
    #1 chk({lock_go, erase_go, write_go, 5'h00, lock_data}, 16'h80C3);
    chk(16'(cpu_halt), 16'h0000);
    waitirq(200);
    chk(16'(page), 16'h0003);
    $display("test lock done errors=%0d", errors);
  endtask

  initial begin
    t_reset(1'b0, BOOT);
    t_reset(1'b1, APP_RESET_ADDR);
    t_timeout;
    t_page;
    t_halt;
    t_clear;
    t_lock;
    summarize;
  end
endmodule // testbench

`default_nettype wire
